/* common/usms_pkg.sv */
package usms_pkg;

   // ------------------------------------------------------------
   // mode, frame and divisor layout
   // ------------------------------------------------------------
   localparam logic [1:0] USMS_MODE_MSPI = 2'b11;   // both select bits set
   localparam int USMS_DIV_WIDTH = 12;
   localparam logic [11:0] USMS_DIV_RESET = 12'h000;
   localparam int USMS_FRAME_BITS = 8;
   localparam logic [3:0] USMS_LAST_EDGE = 4'hf;     // 8 bits = 16 clock edges
   localparam logic [7:0] USMS_DATA_RESET = 8'h00;
   localparam logic [1:0] USMS_RX_DEPTH = 2'h2;      // receive buffer entries
   localparam logic [1:0] USMS_RX_EMPTY = 2'h0;
   localparam logic [1:0] USMS_RX_ONE = 2'h1;

   // ------------------------------------------------------------
   // transfer engine states
   // ------------------------------------------------------------
   typedef enum logic {
      USMS_IDLE = 1'b0,
      USMS_SHIFT = 1'b1
   } usms_state_type;

endpackage

/* common/usms_rate_if.sv */
`timescale 1ns/10ps
// divisor, run request and half-period tick between engine and rate generator
interface usms_rate_if;
   logic [11:0] divisor;
   logic run;
   logic tick;
   modport gen (
      input divisor,
      input run,
      output tick
   );
   modport user (
      output divisor,
      output run,
      input tick
   );
endinterface

/* hdl/usms_master.sv */
`timescale 1ns/10ps
// Functional notes
// - both select bits one enters master mode
// - spi control owns shifters, buffers, rate generator
// - no parity, recovery or async control
// - pin and flag behaviour as normal mode
// - same control locations, changed meanings
// - internal clock only, always master
// - rate is clock over two(divisor+1)
// - twelve-bit divisor from high and low
// - four modes from polarity and phase
// - shift and sample on opposite edges
// - full duplex, selectable bit order
// - double buffered transmit, no gaps
// - eight-bit frames, order for both directions
// - data write starts send and receive
// - framing, overrun, parity flags read zero
// - overflow drops newest byte, keeps older
module usms_master
   import usms_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [1:0] mode_select_field,
   input wire logic clock_polarity_bit,
   input wire logic clock_phase_bit,
   input wire logic bit_order_bit,
   input wire logic transmit_enable_bit,
   input wire logic receive_enable_bit,
   input wire logic clock_pin_direction_bit,
   input wire logic [3:0] rate_divisor_high,
   input wire logic [7:0] rate_divisor_low,
   input wire logic data_wr_strobe,
   input wire logic [7:0] data_wr_value,
   input wire logic data_rd_strobe,
   output logic [7:0] data_rd_value,
   input wire logic tx_complete_clear,
   output logic master_spi_mode,
   output logic tx_buffer_empty,
   output logic tx_complete,
   output logic rx_complete,
   output logic framing_error_flag,
   output logic overrun_flag,
   output logic parity_error_flag,
   output logic transfer_clock_pin_out,
   output logic transfer_clock_pin_oe,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   input wire logic serial_data_in
);

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   // both select bits
   assign master_spi_mode = (mode_select_field == USMS_MODE_MSPI);
   // same controls, meaning by mode
   // enable bits keep their place; in this mode they gate the shared engine
   wire tx_on = master_spi_mode && transmit_enable_bit;
   wire rx_on = master_spi_mode && receive_enable_bit;

   // unused error flags
   // no parity or framing checker exists in this path, so these are constant
   assign framing_error_flag = 1'b0;
   assign overrun_flag = 1'b0;
   assign parity_error_flag = 1'b0;

   // ------------------------------------------------------------
   // pin control
   // ------------------------------------------------------------
   // normal pin overrides
   // clock pin driven only as output
   // the clock pin follows its direction bit as in normal mode;
   // software is expected to set it before enabling
   logic sck_phase;
   logic sdo;
   assign transfer_clock_pin_oe = master_spi_mode && clock_pin_direction_bit;
   assign transfer_clock_pin_out = clock_polarity_bit ^ sck_phase;
   assign serial_data_out = sdo;
   assign serial_data_out_oe = tx_on;

   // ------------------------------------------------------------
   // rate generator
   // ------------------------------------------------------------
   usms_state_type state;
   usms_state_type next_state;
   usms_rate_if rate_bus ();

   assign rate_bus.divisor = {rate_divisor_high, rate_divisor_low};
   assign rate_bus.run = (state == USMS_SHIFT);

   usms_rate_gen u_rate (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .rate(rate_bus.gen)
   );

   // ------------------------------------------------------------
   // transmit buffer
   // ------------------------------------------------------------
   logic [7:0] tx_buf;
   logic tx_full;
   logic [3:0] edge_cnt;
   wire tick = rate_bus.tick;
   wire last_edge = tick && (edge_cnt == USMS_LAST_EDGE);
   wire idle_load = (state == USMS_IDLE) && tx_full && tx_on;
   wire chain_load = last_edge && tx_full;
   wire load = idle_load || chain_load;
   // writes into a full buffer are ignored
   wire wr_take = data_wr_strobe && tx_on && !tx_full;
   assign tx_buffer_empty = !tx_full;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_full <= 1'b0;
         tx_buf <= USMS_DATA_RESET;
      end else if (!tx_on) begin
         tx_full <= 1'b0;
      end else if (wr_take) begin
         tx_full <= 1'b1;
         tx_buf <= data_wr_value;
      end else if (load) begin
         tx_full <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // edge classification
   // ------------------------------------------------------------
   // leading edges are even edge counts
   // setup and sample on opposite edges
   // phase 0 samples on leading, sets up on trailing;
   // phase 1 sets up on leading, samples on trailing
   wire leading = !edge_cnt[0];
   wire sample_edge = tick && (clock_phase_bit ? !leading : leading);
   wire setup_edge = tick && (clock_phase_bit ? leading : (!leading && !last_edge));

   // ------------------------------------------------------------
   // shift data paths
   // ------------------------------------------------------------
   logic [7:0] tx_shift;
   logic [7:0] rx_shift;
   // order shared by both directions
   // order bit high sends and receives the least significant bit first
   wire [7:0] load_word = tx_buf;
   wire load_bit = bit_order_bit ? load_word[0] : load_word[USMS_FRAME_BITS-1];
   wire out_bit = bit_order_bit ? tx_shift[0] : tx_shift[USMS_FRAME_BITS-1];
   wire [7:0] tx_advanced = bit_order_bit ? {1'b0, tx_shift[7:1]} : {tx_shift[6:0], 1'b0};
   // phase 0 already shows the first bit at load, so the shifter starts one step on
   wire [7:0] load_advanced = bit_order_bit ? {1'b0, load_word[7:1]} : {load_word[6:0], 1'b0};
   wire [7:0] rx_advanced = bit_order_bit ? {serial_data_in, rx_shift[7:1]} :
                                            {rx_shift[6:0], serial_data_in};
   // the final sample may land on the closing edge itself
   wire [7:0] rx_word = sample_edge ? rx_advanced : rx_shift;

   // ------------------------------------------------------------
   // transfer state machine
   // ------------------------------------------------------------
   // one common transfer control
   always_comb begin
      next_state = state;
      unique case (state)
         USMS_IDLE: begin
            if (idle_load) begin
               next_state = USMS_SHIFT;
            end
         end
         USMS_SHIFT: begin
            if (!tx_on || (last_edge && !tx_full)) begin
               next_state = USMS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= USMS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // edge counter and clock level; 16 toggles return to idle level
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         edge_cnt <= 4'h0;
         sck_phase <= 1'b0;
      end else if (!tx_on || load) begin
         edge_cnt <= 4'h0;
         sck_phase <= chain_load ? ~sck_phase : 1'b0;
      end else if (tick) begin
         edge_cnt <= edge_cnt + 4'h1;
         sck_phase <= ~sck_phase;
      end
   end

   // transmit shifter
   // phase 0 must present the first bit before the first edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_shift <= USMS_DATA_RESET;
         sdo <= 1'b0;
      end else if (load) begin
         tx_shift <= clock_phase_bit ? load_word : load_advanced;
         if (!clock_phase_bit) begin
            sdo <= load_bit;
         end
      end else if (setup_edge) begin
         tx_shift <= tx_advanced;
         sdo <= out_bit;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_shift <= USMS_DATA_RESET;
      end else if (sample_edge) begin
         rx_shift <= rx_advanced;
      end
   end

   // ------------------------------------------------------------
   // transmit complete flag
   // ------------------------------------------------------------
   // set when the last frame ends with nothing queued; set beats clear
   wire tx_done = last_edge && !tx_full;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_complete <= 1'b0;
      end else if (tx_done) begin
         tx_complete <= 1'b1;
      end else if (tx_complete_clear) begin
         tx_complete <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // receive buffer
   // ------------------------------------------------------------
   logic [7:0] rx_slot [0:1];
   logic [1:0] rx_count;
   logic [1:0] next_rx_count;
   wire rx_push = last_edge && rx_on;
   wire rx_pop = data_rd_strobe && (rx_count != USMS_RX_EMPTY);
   // newest byte lost on overflow
   // a pop in the same cycle frees a slot, so the byte is kept then
   wire rx_store = rx_push && (rx_pop || (rx_count != USMS_RX_DEPTH));
   assign next_rx_count = rx_count + {1'b0, rx_store} - {1'b0, rx_pop};
   // slot 0 is always the oldest byte, read straight from a flop
   wire [1:0] wr_slot_idx = rx_count - {1'b0, rx_pop};
   assign data_rd_value = rx_slot[0];
   assign rx_complete = (rx_count != USMS_RX_EMPTY);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_count <= USMS_RX_EMPTY;
      end else if (!rx_on) begin
         rx_count <= USMS_RX_EMPTY;
      end else begin
         rx_count <= next_rx_count;
      end
   end

   // per-slot update: move forward on pop, then take the new byte
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_slot
         wire take = rx_store && (wr_slot_idx == 2'(gi));
         always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               rx_slot[gi] <= USMS_DATA_RESET;
            end else if (take) begin
               rx_slot[gi] <= rx_word;
            end else if (rx_pop && gi == 0) begin
               rx_slot[gi] <= rx_slot[1];
            end
         end
      end
   endgenerate

endmodule

/* hdl/usms_rate_gen.sv */
`timescale 1ns/10ps
module usms_rate_gen
   import usms_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   usms_rate_if.gen rate
);

   // ------------------------------------------------------------
   // half-period counter
   // ------------------------------------------------------------
   logic [11:0] count;
   logic [11:0] next_count;
   wire count_done = (count == rate.divisor);

   // divisor plus one per half
   // each half period lasts divisor+1 cycles, so the full
   // transfer clock period is 2*(divisor+1) system clocks
   assign next_count = (!rate.run || count_done) ? USMS_DIV_RESET : count + 12'h001;
   assign rate.tick = rate.run && count_done;

   // counter restarts while stopped so the first half is full
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= USMS_DIV_RESET;
      end else begin
         count <= next_count;
      end
   end

endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import usms_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] mode_select_field = 2'b11;
   logic clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, bit_order_bit = 1'b0;
   logic transmit_enable_bit = 1'b0, receive_enable_bit = 1'b1, clock_pin_direction_bit = 1'b1;
   logic [3:0] rate_divisor_high = 4'h0;
   logic [7:0] rate_divisor_low = 8'h00, data_wr_value = 8'h00, data_rd_value, last_rx;
   logic data_wr_strobe = 1'b0, data_rd_strobe = 1'b0, tx_complete_clear = 1'b0;
   logic master_spi_mode, tx_buffer_empty, tx_complete, rx_complete, framing_error_flag;
   logic overrun_flag, parity_error_flag, transfer_clock_pin_out, transfer_clock_pin_oe;
   logic serial_data_out, serial_data_out_oe, serial_data_in;
   int miscompares = 0, checks_done = 0;
   integer seed = 32'h5fb216c0;
   logic [7:0] prev, b0, b1, b2;
   usms_master DUT (.*);
   usms_spi_slave PEER (.sys_clk, .rst_b, .sclk(transfer_clock_pin_out), .mosi(serial_data_out),
      .cpol(clock_polarity_bit), .cpha(clock_phase_bit), .lsb_first(bit_order_bit),
      .miso(serial_data_in), .last_rx);
   always #5 sys_clk = ~sys_clk;
   // ------------------------------------------
   // bus tasks and verdict
   // ------------------------------------------
   task automatic tally_and_finish();
      if (miscompares == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // bounded wait so a stuck flag cannot hang the run
   task automatic wr(input logic [7:0] b);
      for (int n = 0; n < 9000 && tx_buffer_empty !== 1'b1; n++) tick(1);
      data_wr_value = b;
      data_wr_strobe = 1'b1;
      tick(1);
      data_wr_strobe = 1'b0;
   endtask
   task automatic rd(input logic [7:0] exp);
      for (int n = 0; n < 9000 && rx_complete !== 1'b1; n++) tick(1);
      chk("received byte", exp, data_rd_value);
      data_rd_strobe = 1'b1;
      tick(1);
      data_rd_strobe = 1'b0;
      tick(1);
   endtask
   initial begin
      #600000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      prev = 8'h5a;
      tick(2);
      chk("empty flag at reset", 8'h01, {7'h0, tx_buffer_empty});
      rst_b = 1'b1;
      chk("clock pin at reset", 8'h00, {7'h0, transfer_clock_pin_out});
      transmit_enable_bit = 1'b1;
      mode_select_field = 2'b01;
      wr(8'h3c);
      tick(2);
      chk("mode off empty flag", 8'h01, {7'h0, tx_buffer_empty});
      chk("mode off pin enable", 8'h00, {7'h0, transfer_clock_pin_oe});
      mode_select_field = 2'b11;
      for (int i = 0; i < 8; i++) begin
         {bit_order_bit, clock_phase_bit, clock_polarity_bit} = i[2:0];
         {rate_divisor_high, rate_divisor_low} = (i == 7) ? 12'h101 : 12'($random(seed) & 3) + 12'h1;
         tx_complete_clear = 1'b1;
         tick(1);
         tx_complete_clear = 1'b0;
         chk("done flag cleared", 8'h00, {7'h0, tx_complete});
         b0 = 8'($random(seed));
         b1 = 8'($random(seed));
         wr(b0);
         wr(b1);
         rd(~prev);
         rd(~b0);
         chk("slave byte", b1, last_rx);
         chk("done flag", 8'h01, {7'h0, tx_complete});
         prev = b1;
      end
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      // done flag still set from the loop; clear it so the wait below means something
      tx_complete_clear = 1'b1;
      tick(1);
      tx_complete_clear = 1'b0;
      chk("done flag cleared before burst", 8'h00, {7'h0, tx_complete});
      wr(b0);
      wr(b1);
      wr(b2);
      for (int n = 0; n < 9000 && tx_complete !== 1'b1; n++) tick(1);
      tick(3);
      rd(~prev);
      rd(~b0);
      chk("dropped byte", 8'h00, {7'h0, rx_complete});
      chk("error flags", 8'h00, {5'h0, framing_error_flag, overrun_flag, parity_error_flag});
      tally_and_finish();
   end
endmodule

/* verification/usms_master_properties.sv */
`timescale 1ns/10ps
module usms_master_properties
   import usms_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [1:0] mode_select_field,
   input wire logic clock_polarity_bit,
   input wire logic clock_phase_bit,
   input wire logic transmit_enable_bit,
   input wire logic clock_pin_direction_bit,
   input wire logic [3:0] rate_divisor_high,
   input wire logic [7:0] rate_divisor_low,
   input wire logic data_wr_strobe,
   input wire logic data_rd_strobe,
   input wire logic [7:0] data_rd_value,
   input wire logic master_spi_mode,
   input wire logic tx_buffer_empty,
   input wire logic rx_complete,
   input wire logic framing_error_flag,
   input wire logic overrun_flag,
   input wire logic parity_error_flag,
   input wire logic transfer_clock_pin_out,
   input wire logic transfer_clock_pin_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe
);
   // ------------------------------------------
   // clock pin edge count and spacing
   // ------------------------------------------
   logic act_q;
   logic [3:0] edges;
   logic [12:0] gap;
   // polarity folded out, so a polarity change while idle is no edge
   wire act = transfer_clock_pin_out ^ clock_polarity_bit;
   wire tog = act != act_q;
   wire run = master_spi_mode && transmit_enable_bit;
   wire [12:0] half = {1'b0, rate_divisor_high, rate_divisor_low} + 13'h1;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         act_q <= 1'b0;
         edges <= 4'h0;
         gap <= 13'h0;
      end else begin
         act_q <= act;
         edges <= run ? edges + {3'h0, tog} : 4'h0;
         gap <= tog ? 13'h1 : gap + 13'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_MODE: assert property (master_spi_mode == (mode_select_field == USMS_MODE_MSPI))
      else $error("mode flag wrong");
   AST_REFUSED: assert property (data_wr_strobe && !master_spi_mode && tx_buffer_empty |=> tx_buffer_empty)
      else $error("write taken outside master mode");
   AST_ERR_FLAGS: assert property (!(framing_error_flag || overrun_flag || parity_error_flag))
      else $error("receive error flag set");
   AST_PIN_OE: assert property (transfer_clock_pin_oe == (master_spi_mode && clock_pin_direction_bit)
      && serial_data_out_oe == run) else $error("pin enable wrong");
   AST_IDLE_LEVEL: assert property (!run ##1 !run |-> !act)
      else $error("clock pin off idle level");
   AST_HALF_PERIOD: assert property (run && tog && edges != 4'h0 |-> gap == half)
      else $error("clock half period wrong");
   AST_SHIFT_EDGE: assert property (run && edges != 4'h0 && edges != 4'hf && $changed(serial_data_out)
      |-> tog && act == clock_phase_bit) else $error("data changed off setup edge");
   AST_WRITE_TAKEN: assert property (data_wr_strobe && run && tx_buffer_empty |=> !tx_buffer_empty)
      else $error("write not taken");
   AST_OLDEST_KEPT: assert property (master_spi_mode && rx_complete && !data_rd_strobe
      |=> $stable(data_rd_value)) else $error("oldest byte replaced");
endmodule
bind usms_master usms_master_properties u_props (.*);

/* verification/usms_spi_slave.sv */
`timescale 1ns/10ps
// ------------------------------------------
// slave model, answers with the inverse of the last byte
// ------------------------------------------
module usms_spi_slave (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first,
   output logic miso,
   output logic [7:0] last_rx
);
   logic a_q, junk;
   logic [3:0] ecnt;
   logic [7:0] rx_sr, rx_nx, echo;
   wire a = sclk ^ cpol;
   wire edge_seen = a != a_q;
   wire samp = edge_seen && (a ^ cpha);
   wire [2:0] oidx = ecnt[3:1] - {2'h0, cpha & ~ecnt[0]};
   wire [2:0] ipos = lsb_first ? ecnt[3:1] : 3'h7 - ecnt[3:1];
   wire [2:0] opos = lsb_first ? oidx : 3'h7 - oidx;
   // undriven before the first edge in phase 1, so show a moving pattern
   assign miso = (cpha && ecnt == 4'h0) ? junk : echo[opos];
   always_comb begin
      rx_nx = rx_sr;
      if (samp) begin
         rx_nx[ipos] = mosi;
      end
   end
   // edges seen one cycle late; fine for divisors of one and up
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         a_q <= 1'b0;
         junk <= 1'b0;
         ecnt <= 4'h0;
         rx_sr <= 8'h00;
         echo <= 8'ha5;
         last_rx <= 8'h00;
      end else begin
         a_q <= a;
         junk <= ~junk;
         rx_sr <= rx_nx;
         ecnt <= ecnt + {3'h0, edge_seen};
         if (edge_seen && ecnt == 4'hf) begin
            last_rx <= rx_nx;
            echo <= ~rx_nx;
         end
      end
   end
endmodule
